// ---- adc_computation_unit.sv ----
// What this block does
// - Mode 000 passes results straight through; no accumulation or filtering, threshold works.
// - Mode 001 adds every new conversion result into the accumulator.
// - Accumulator stays right-justified whatever result justification is chosen.
// - In accumulate mode the sample counter increments once per sample and saturates at FFFF.
// - After each accumulation, filter result takes accumulator shifted right by shift select.
// - After each accumulation, threshold comparison runs and may set the threshold flag.
// - Start flag clears after the fixed conversion time from being set.
// - Mode codes: 000 basic, 001 accum, 010 avg, 011 burst, 100 filter; rest reserved.
// - Shift codes 110/111 reserved; divisions by two to the shift truncate.
// - Clear command zeroes accumulator, overflow flag, counter; hardware then drops it.
// - At conversion start previous sample takes filter result or conversion result.
module adc_computation_unit
    import adc_comp_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic [9:0] sample_data_i,
    output logic conv_start_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Register port decode.
    reg_req_t req;
    assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

    wire wr_ctrl = req.wr && (req.addr == OFS_CTRL);
    wire wr_thresh = req.wr && (req.addr == OFS_THRESH);
    wire wr_irq_clr = req.wr && (req.addr == OFS_IRQ_CLR);
    wire wr_irq_en = req.wr && (req.addr == OFS_IRQ_EN);
    wire wr_start = req.wr && (req.addr == OFS_START) && req.wdata[START_BIT];

    ctrl_t ctrl_ff;
    logic [15:0] thresh_ff;
    logic [2:0] irq_en_ff;
    logic [2:0] status_ff;
    logic [15:0] result_ff;
    logic [15:0] acc_ff;
    logic [15:0] count_ff;
    logic [15:0] filter_ff;
    logic [15:0] prev_ff;
    logic ovf_ff;
    logic busy_ff;
    logic [7:0] conv_cnt_ff;
    logic [31:0] rdata_ff;

    // Sample input comes from the analogue core, so it is synchronised first.
    logic [9:0] sample_s1_ff;
    logic [9:0] sample_s2_ff;
    always_ff @(posedge clk_sys_i) begin
        sample_s1_ff <= sample_data_i;
        sample_s2_ff <= sample_s1_ff;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode decoding; reserved codes behave as basic mode.
    function automatic logic is_accumulating(input logic [2:0] m);
        return (m == MODE_ACCUM) || (m == MODE_AVG) || (m == MODE_BURST) || (m == MODE_LPF);
    endfunction

    wire [2:0] mode = ctrl_ff.computation_mode_select;
    wire acc_mode = is_accumulating(mode);
    // Reserved shift codes are clamped to the largest legal shift.
    wire [2:0] shift_eff = (ctrl_ff.shift_select > SHIFT_MAX) ? SHIFT_MAX
                                                             : ctrl_ff.shift_select;

    ////////////////////////////////////////////////////////////////////////////
    // Conversion timing and computation datapath.
    wire conv_done = busy_ff && (conv_cnt_ff == 8'(CONV_CYC - 1));
    wire conv_begin = wr_start && !busy_ff;
    wire [15:0] sample_rj = {6'h00, sample_s2_ff};
    wire [15:0] sample_fmt = ctrl_ff.justify_left ? {sample_s2_ff, 6'h00} : sample_rj;
    wire [16:0] acc_sum = {1'b0, acc_ff} + {1'b0, sample_rj};
    wire [15:0] nxt_acc = acc_sum[15:0];
    wire [15:0] nxt_filter = nxt_acc >> shift_eff;
    // Basic mode compares the raw result; otherwise the freshly filtered value.
    wire [15:0] cmp_value = acc_mode ? nxt_filter : sample_rj;
    wire thresh_hit = conv_done && (cmp_value > thresh_ff);
    wire ovf_event = conv_done && acc_mode && acc_sum[16];
    wire [2:0] irq_events = {ovf_event, conv_done, thresh_hit};
    wire [2:0] irq_clear = wr_irq_clr ? req.wdata[2:0] : 3'h0;

    // Control register; hardware drops the clear command on the same edge that it acts.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ctrl_ff <= ctrl_t'(CTRL_RST);
        end else if (wr_ctrl) begin
            ctrl_ff <= ctrl_t'(req.wdata[8:0]);
        end else if (ctrl_ff.accumulator_clear_cmd) begin
            ctrl_ff.accumulator_clear_cmd <= 1'b0;
        end
    end

    // Threshold and interrupt enable registers.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            thresh_ff <= THRESH_RST;
            irq_en_ff <= 3'h0;
        end else begin
            if (wr_thresh) thresh_ff <= req.wdata[15:0];
            if (wr_irq_en) irq_en_ff <= req.wdata[2:0];
        end
    end

    // Sticky status: a new event wins over a clear in the same cycle.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            status_ff <= 3'h0;
        end else begin
            status_ff <= (status_ff & ~irq_clear) | irq_events;
        end
    end

    // Conversion sequencer: start flag stays set for the conversion time.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            busy_ff <= 1'b0;
            conv_cnt_ff <= 8'h00;
        end else if (conv_begin) begin
            busy_ff <= 1'b1;
            conv_cnt_ff <= 8'h00;
        end else if (conv_done) begin
            busy_ff <= 1'b0;
        end else if (busy_ff) begin
            conv_cnt_ff <= conv_cnt_ff + 8'h01;
        end
    end

    // Previous sample is captured as a conversion starts.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            prev_ff <= 16'h0000;
        end else if (conv_begin) begin
            prev_ff <= ctrl_ff.previous_input_select ? filter_ff : result_ff;
        end
    end

    // Result, accumulator, counter and filter update at conversion end.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            result_ff <= 16'h0000;
            acc_ff <= 16'h0000;
            count_ff <= 16'h0000;
            filter_ff <= 16'h0000;
            ovf_ff <= 1'b0;
        end else begin
            if (conv_done) result_ff <= sample_fmt;
            if (ctrl_ff.accumulator_clear_cmd) begin
                acc_ff <= 16'h0000;
                count_ff <= 16'h0000;
                ovf_ff <= 1'b0;
            end else if (conv_done && acc_mode) begin
                acc_ff <= nxt_acc;
                count_ff <= (count_ff == 16'hFFFF) ? count_ff : count_ff + 16'h0001;
                filter_ff <= nxt_filter;
                ovf_ff <= ovf_ff | acc_sum[16];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe; unmapped addresses read zero.
    logic [31:0] rd_mux;
    always_comb begin
        case (req.addr)
            OFS_CTRL: rd_mux = {23'h000000, ctrl_ff};
            OFS_RESULT: rd_mux = {16'h0000, result_ff};
            OFS_ACC: rd_mux = {15'h0000, ovf_ff, acc_ff};
            OFS_COUNT: rd_mux = {16'h0000, count_ff};
            OFS_FILTER: rd_mux = {16'h0000, filter_ff};
            OFS_PREV: rd_mux = {16'h0000, prev_ff};
            OFS_THRESH: rd_mux = {16'h0000, thresh_ff};
            OFS_STATUS: rd_mux = {29'h00000000, status_ff};
            OFS_IRQ_EN: rd_mux = {29'h00000000, irq_en_ff};
            OFS_START: rd_mux = {31'h00000000, busy_ff};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdata_ff <= 32'h00000000;
        end else begin
            rdata_ff <= req.rd ? rd_mux : 32'h00000000;
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign conv_start_o = busy_ff;
    assign irq_o = |(status_ff & irq_en_ff);

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence s_start;
        wr_start && !busy_ff;
    endsequence

    a_mode_basic_idle: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (conv_done && !acc_mode && !ctrl_ff.accumulator_clear_cmd) |=> $stable(acc_ff))
        else $error("Accumulator changed in basic mode.");

    a_accum_adds: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (conv_done && mode == MODE_ACCUM && !ctrl_ff.accumulator_clear_cmd)
        |=> acc_ff == $past(acc_ff) + $past(sample_rj))
        else $error("Accumulator did not add the sample.");

    a_acc_right_just: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (conv_done && acc_mode && acc_ff == 16'h0000 && !ctrl_ff.accumulator_clear_cmd)
        |=> acc_ff[15:10] == 6'h00)
        else $error("Accumulator not right-justified.");

    a_count_step: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (conv_done && acc_mode && !ctrl_ff.accumulator_clear_cmd && count_ff != 16'hFFFF)
        |=> count_ff == $past(count_ff) + 16'h0001)
        else $error("Sample counter did not step.");

    a_filter_shift: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (conv_done && acc_mode && !ctrl_ff.accumulator_clear_cmd)
        |=> filter_ff == (acc_ff >> $past(shift_eff)))
        else $error("Filter result is not the shifted accumulator.");

    a_thresh_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        thresh_hit |=> status_ff[IRQ_THRESH])
        else $error("Threshold flag not set.");

    // The start flag stands for CONV_CYC (23) cycles, counted as runs of 8, 8 and 7.
    sequence s_busy_run;
        busy_ff [*8] ##1 busy_ff [*8] ##1 busy_ff [*7];
    endsequence

    a_conv_time: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        s_start |=> s_busy_run ##1 !busy_ff)
        else $error("Conversion time wrong.");

    a_clear_cmd: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ctrl_ff.accumulator_clear_cmd && !wr_ctrl)
        |=> acc_ff == 16'h0000 && count_ff == 16'h0000 && !ovf_ff
            && !ctrl_ff.accumulator_clear_cmd)
        else $error("Accumulator clear failed.");

    a_prev_capture: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        s_start |=> prev_ff == ($past(ctrl_ff.previous_input_select) ? $past(filter_ff)
                                                                   : $past(result_ff)))
        else $error("Previous sample not captured.");

    a_prev_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !conv_begin |=> $stable(prev_ff))
        else $error("Previous sample moved outside a conversion start.");

    // Basic mode: the result passes straight through, filter and counter hold, and the threshold check still runs.
    a_basic_result: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (conv_done && !acc_mode && !ctrl_ff.justify_left)
        |=> result_ff == {6'h00, $past(sample_s2_ff)})
        else $error("Basic mode result is not the raw sample.");

    a_basic_no_filter: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (conv_done && !acc_mode && !ctrl_ff.accumulator_clear_cmd)
        |=> $stable(filter_ff) && $stable(count_ff))
        else $error("Filter or counter moved in basic mode.");

    a_basic_thresh: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (conv_done && !acc_mode && sample_rj > thresh_ff) |=> status_ff[IRQ_THRESH])
        else $error("Threshold detection lost in basic mode.");

    // A left-justified result must not leak its format into the accumulator.
    a_acc_left_fmt: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (conv_done && acc_mode && ctrl_ff.justify_left && !ctrl_ff.accumulator_clear_cmd)
        |=> acc_ff == $past(acc_ff) + {6'h00, $past(sample_s2_ff)})
        else $error("Accumulator followed the result justification.");

    // Counter, accumulator and filter move only on a finished sample or a clear.
    a_sample_once: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (!conv_done && !ctrl_ff.accumulator_clear_cmd)
        |=> $stable(count_ff) && $stable(acc_ff))
        else $error("Counter or accumulator moved without a sample.");

    a_filter_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !conv_done |=> $stable(filter_ff))
        else $error("Filter result moved without a sample.");

    // Every event reaches its sticky bit, even against a clear in the same cycle.
    a_status_set_wins: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (|irq_events) |=> ((status_ff & $past(irq_events)) == $past(irq_events)))
        else $error("Status event lost.");

    a_thresh_cause: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (!thresh_hit && !status_ff[IRQ_THRESH]) |=> !status_ff[IRQ_THRESH])
        else $error("Threshold flag set without a hit.");

    a_done_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        conv_done |=> status_ff[IRQ_DONE] && !busy_ff)
        else $error("Completion not flagged.");

    // A start written during a conversion is ignored: the count runs on.
    a_restart_ignored: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (wr_start && busy_ff && !conv_done)
        |=> busy_ff && (conv_cnt_ff == $past(conv_cnt_ff) + 8'h01))
        else $error("Start during a conversion restarted it.");

    a_start_readback: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (req.rd && req.addr == OFS_START) |=> reg_rdata_o == {31'h0, $past(busy_ff)})
        else $error("Start flag read back wrong.");

    // Basic and reserved codes leave the accumulator alone; 001 to 100 all add.
    a_mode_idle_codes: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (conv_done && !ctrl_ff.accumulator_clear_cmd
            && (mode == MODE_BASIC || mode > MODE_LPF))
        |=> $stable(acc_ff))
        else $error("Basic or reserved mode code accumulated.");

    a_mode_add_codes: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (conv_done && !ctrl_ff.accumulator_clear_cmd
            && mode >= MODE_ACCUM && mode <= MODE_LPF)
        |=> acc_ff == $past(acc_ff) + $past(sample_rj))
        else $error("Accumulating mode code did not add.");

    a_shift_clamp: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (conv_done && acc_mode && ctrl_ff.shift_select > SHIFT_MAX
            && !ctrl_ff.accumulator_clear_cmd)
        |=> filter_ff == (acc_ff >> SHIFT_MAX))
        else $error("Reserved shift code not clamped.");

    a_ovf_sticky: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ovf_ff && !ctrl_ff.accumulator_clear_cmd) |=> ovf_ff)
        else $error("Overflow flag dropped without a clear.");

    // Clearing takes two steps: the command bit is written, then it acts and drops.
    sequence s_clear_write;
        wr_ctrl && req.wdata[CLR_BIT];
    endsequence

    sequence s_clear_done;
        acc_ff == 16'h0000 && count_ff == 16'h0000
            && !ovf_ff && !ctrl_ff.accumulator_clear_cmd;
    endsequence

    a_clear_flow: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        s_clear_write ##1 !wr_ctrl |=> s_clear_done)
        else $error("Clear command did not complete.");

endmodule // adc_computation_unit

// ---- adc_comp_pkg.sv ----
package adc_comp_pkg;

    // Register word offsets on the plain register port.
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_RESULT = 4'h1;
    localparam logic [3:0] OFS_ACC = 4'h2;
    localparam logic [3:0] OFS_COUNT = 4'h3;
    localparam logic [3:0] OFS_FILTER = 4'h4;
    localparam logic [3:0] OFS_PREV = 4'h5;
    localparam logic [3:0] OFS_THRESH = 4'h6;
    localparam logic [3:0] OFS_STATUS = 4'h7;
    localparam logic [3:0] OFS_IRQ_CLR = 4'h8;
    localparam logic [3:0] OFS_IRQ_EN = 4'h9;
    localparam logic [3:0] OFS_START = 4'hA;

    // Control word field positions and the start register bit.
    localparam int MODE_LSB = 0;
    localparam int CLR_BIT = 3;
    localparam int SHIFT_LSB = 4;
    localparam int PSIS_BIT = 7;
    localparam int JUST_BIT = 8;
    localparam int START_BIT = 0;

    // Status and interrupt bit positions.
    localparam int IRQ_THRESH = 0;
    localparam int IRQ_DONE = 1;
    localparam int IRQ_OVF = 2;

    // Reset values.
    localparam logic [8:0] CTRL_RST = 9'h000;
    localparam logic [15:0] THRESH_RST = 16'hFFFF;

    // Conversion time: 11 converter clocks plus 3 instruction cycles.
    localparam int CONV_BASE_CYC = 11;
    localparam int INSTR_CYCLES = 3;
    localparam int INSTR_CYCLE_NS = 16;
    localparam int CLK_PERIOD_NS = 4;
    localparam int CONV_CYC = CONV_BASE_CYC
        + (INSTR_CYCLES * INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [2:0] SHIFT_MAX = 3'h5;

    // Computation modes.
    typedef enum logic [2:0] {
        MODE_BASIC = 3'h0,
        MODE_ACCUM = 3'h1,
        MODE_AVG = 3'h2,
        MODE_BURST = 3'h3,
        MODE_LPF = 3'h4
    } comp_mode_t;

    // Control fields as software sees them.
    typedef struct packed {
        logic justify_left;
        logic previous_input_select;
        logic [2:0] shift_select;
        logic accumulator_clear_cmd;
        logic [2:0] computation_mode_select;
    } ctrl_t;

    // Register port request.
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage

// ---- adc_core_model.sv ----
module adc_core_model (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic conv_start_i,
    input wire logic [9:0] sample_value_i,
    output logic [9:0] sample_data_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Holds the sample while converting; idle lines toggle so stale data never looks valid.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sample_data_o <= 10'h2AA;
        end else if (conv_start_i) begin
            sample_data_o <= sample_value_i;
        end else begin
            sample_data_o <= ~sample_data_o;
        end
    end
endmodule // adc_core_model

// ---- adc_computation_unit_tb.sv ----
module adc_computation_unit_tb
    import adc_comp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i;
    logic rst_i;
    logic [3:0] reg_addr_i;
    logic [31:0] reg_wdata_i;
    logic reg_wr_i;
    logic reg_rd_i;
    logic [31:0] reg_rdata_o;
    logic [9:0] sample_data_i;
    logic conv_start_o;
    logic irq_o;
    logic [9:0] sample_value;
    logic [31:0] v;
    logic [31:0] acc;
    logic thr;
    logic [9:0] smp [3] = '{10'h3FF, 10'h3FF, 10'h001};
    int n_errors;
    int cmp_count;

    ////////////////////////////////////////////////////////////////////////////
    // Design and analogue core model.
    adc_computation_unit adc_computation_unit_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .sample_data_i(sample_data_i),
        .conv_start_o(conv_start_o), .irq_o(irq_o));
    adc_core_model adc_core_model_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .conv_start_i(conv_start_o), .sample_value_i(sample_value),
        .sample_data_o(sample_data_i));

    ////////////////////////////////////////////////////////////////////////////
    // Clock at 4 ns.
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    // Compares, counts and reports.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // One-cycle register write and read; read data stand in the following cycle only.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    task automatic rdc(input string name, input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        check(name, d, exp);
    endtask

    // Runs one conversion and measures how long the start flag stays up.
    task automatic conv(input logic [9:0] s);
        int n;
        int k;
        n = 0;
        sample_value = s;
        wr(OFS_START, 32'h1);
        #1;
        for (k = 0; k < 100 && conv_start_o === 1'b1; k++) begin
            n++;
            @(posedge clk_sys_i);
            #1;
        end
        if (conv_start_o !== 1'b0) begin
            n_errors++;
            wrap_up();
        end else begin
            check("busy cycles", n, CONV_CYC);
        end
    endtask

    function automatic logic [31:0] cw(input logic [2:0] m, input logic [2:0] s, input logic c,
        input logic p, input logic j);
        ctrl_t t;
        t = '{j, p, s, c, m};
        return {23'h0, t};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        rst_i = 1'b1;
        reg_addr_i = 4'h0;
        reg_wdata_i = 32'h0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        sample_value = 10'h0;
        n_errors = 0;
        cmp_count = 0;
        acc = 32'h0;
        thr = 1'b0;
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        check("irq", irq_o, 32'h0);
        rdc("ctrl", OFS_CTRL, {23'h0, CTRL_RST});
        rdc("thresh", OFS_THRESH, {16'h0, THRESH_RST});
        rdc("unmapped", 4'hB, 32'h0);
        $display("test reset done");
        wr(OFS_THRESH, 32'h100);
        wr(OFS_IRQ_EN, 32'h1);
        conv(10'h155);
        rdc("result", OFS_RESULT, 32'h155);
        rdc("acc", OFS_ACC, 32'h0);
        rdc("status", OFS_STATUS, 32'h3);
        check("irq", irq_o, 32'h1);
        wr(OFS_IRQ_EN, 32'h0);
        #1 check("irq", irq_o, 32'h0);
        wr(OFS_IRQ_EN, 32'h1);
        wr(OFS_IRQ_CLR, 32'h1);
        #1 check("irq", irq_o, 32'h0);
        $display("test basic done");
        wr(OFS_CTRL, cw(3'h1, 3'h2, 1'b1, 1'b0, 1'b1));
        wr(OFS_THRESH, 32'h150);
        wr(OFS_IRQ_CLR, 32'h7);
        rdc("clear cmd", OFS_CTRL, cw(3'h1, 3'h2, 1'b0, 1'b0, 1'b1));
        for (int i = 0; i < 3; i++) begin
            conv(smp[i]);
            acc = acc + smp[i];
            thr = thr | ((acc >> 2) > 32'h150);
            rdc("acc", OFS_ACC, acc);
            rdc("count", OFS_COUNT, i + 1);
            rdc("filter", OFS_FILTER, acc >> 2);
            rdc("result", OFS_RESULT, {16'h0, smp[i], 6'h00});
            rdc("status", OFS_STATUS, {30'h0, 1'b1, thr});
        end
        wr(OFS_CTRL, cw(3'h1, 3'h7, 1'b0, 1'b0, 1'b1));
        conv(10'h0);
        rdc("filter", OFS_FILTER, 32'h3F);
        wr(OFS_CTRL, cw(3'h1, 3'h7, 1'b0, 1'b1, 1'b1));
        conv(10'h0);
        rdc("prev", OFS_PREV, 32'h3F);
        wr(OFS_CTRL, cw(3'h1, 3'h0, 1'b0, 1'b0, 1'b0));
        conv(10'h2A);
        conv(10'h0);
        rdc("prev", OFS_PREV, 32'h2A);
        $display("test accumulate done");
        wr(OFS_CTRL, cw(3'h1, 3'h0, 1'b1, 1'b0, 1'b0));
        rdc("count", OFS_COUNT, 32'h0);
        repeat (65) conv(10'h3FF);
        rd(OFS_ACC, v);
        check("overflow", v[16], 32'h1);
        rdc("status", OFS_STATUS, 32'h7);
        wr(OFS_CTRL, cw(3'h1, 3'h0, 1'b1, 1'b0, 1'b0));
        rdc("acc", OFS_ACC, 32'h0);
        // A second start during a conversion is ignored; the flag still drops on time.
        wr(OFS_START, 32'h1);
        wr(OFS_START, 32'h1);
        rdc("busy", OFS_START, 32'h1);
        // Lands the next read on the last busy cycle of the first start.
        repeat (CONV_CYC - 6) @(posedge clk_sys_i);
        rdc("busy", OFS_START, 32'h1);
        rdc("busy", OFS_START, 32'h0);
        $display("test overflow done");
        for (int m = 0; m < 8; m++) begin
            wr(OFS_CTRL, cw(m[2:0], 3'h0, 1'b1, 1'b0, 1'b0));
            conv(10'h10);
            rdc("mode acc", OFS_ACC, (m >= 1 && m <= 4) ? 32'h10 : 32'h0);
        end
        $display("test modes done");
        wrap_up();
    end
endmodule // adc_computation_unit_tb
